// file: rtl/wakeup_keepalive_timer.sv
// Wake-up interval timer, keep-alive timer, Z gain trim and keep-alive status.
//
// Overview of operation
// [RULE1] Z gain trim is six-bit two's complement, bit 5 sign, 1.56 percent per step.
// [RULE2] User gain trim adds to factory trim within one shared saturating range.
// [RULE3] Wake selector 00/01/10/11 gives 80/160/320/640 ms; reset value is 00.
// [RULE4] Heartbeat code 00000 keeps the keep-alive timer off with no flag.
// [RULE5] Codes 00001 to 10100 give 160 ms doubling up to 23.2 hours; code 10100 here gives 2^20 ticks of 80 ms, about 23.3 hours.
// [RULE6] Each keep-alive expiry sets bit 4 of the second status register.
// [RULE7] Any read of the second status register clears the keep-alive flag.
// [RULE8] Keep-alive status can be routed to either interrupt pin.
// [RULE9] Pin one asserts on keep-alive only when map bit 4 is one.
// [RULE10] Heartbeat codes above 10100 are reserved and keep the timer off.
`timescale 1ns/1ps
`default_nettype none
module wakeup_keepalive_timer #(
  parameter int BASE_TICK_CYCLES = wkt_pkg::BASE_TICK_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic signed [5:0] factory_gain_trim,
  output logic signed [6:0]      z_gain_total,
  output logic                   wake_pulse,
  output logic                   heartbeat_pulse,
  output logic                   interrupt_pin_one,
  output logic                   interrupt_pin_two
);
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]  z_trim_reg;
  logic [7:0]  wake_and_heartbeat_timer_control_reg;
  logic [7:0]  intmap1_reg;
  logic [7:0]  intmap2_reg;
  logic        hb_flag_reg;
  logic [3:0]  wake_cnt_reg;
  localparam int HB_W = wkt_pkg::HB_CNT_W;
  logic [HB_W-1:0] hb_cnt_reg;

  wire         base_tick;

  // The divider free-runs: a control write restarts the counters but not the tick phase,
  // so the first period after a write may be up to one tick short.
  tick_divider #(
    .DIV (BASE_TICK_CYCLES)
  ) u_tick (
    .clk    (clk),
    .resetn (resetn),
    .tick   (base_tick)
  );

  // ****************************************
  // Functions
  // ****************************************
  // One compare shared by every strobe decode, so reads and writes see the same map.
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
    addr_hit = (a == target);
  endfunction

  // Last count of a period of 2^sel ticks; the counter wraps on this value.
  function automatic logic [HB_W-1:0] last_count(input logic [4:0] sel);
    logic [HB_W:0] span;
    span = (HB_W+1)'(1) << sel;
    last_count = HB_W'(span - (HB_W+1)'(1));
  endfunction

  // ****************************************
  // Decode
  // ****************************************
  wire wr_z      = reg_wr && addr_hit(reg_addr, wkt_pkg::ADDR_Z_GAIN_TRIM);
  wire wr_tctl   = reg_wr && addr_hit(reg_addr, wkt_pkg::ADDR_WAKE_AND_HEARTBEAT_TIMER_CONTROL);
  wire wr_map1   = reg_wr && addr_hit(reg_addr, wkt_pkg::ADDR_INTMAP1_UP);
  wire wr_map2   = reg_wr && addr_hit(reg_addr, wkt_pkg::ADDR_INTMAP2_UP);
  wire rd_stat2  = reg_rd && addr_hit(reg_addr, wkt_pkg::ADDR_SECOND_STATUS_REG);

  wire [1:0] wake_interval_sel = wake_and_heartbeat_timer_control_reg[wkt_pkg::WAKE_SEL_LSB +: 2];
  wire [4:0] hb_sel            = wake_and_heartbeat_timer_control_reg[wkt_pkg::HB_SEL_W-1:0];

  // A reserved code behaves as off, so a bad write never produces spurious flags.
  wire hb_enabled = (hb_sel != wkt_pkg::HB_CODE_OFF) && (hb_sel <= wkt_pkg::HB_CODE_MAX); // [RULE4] [RULE10]

  // Code n expires after 2^n base ticks of 80 ms: code 1 is 160 ms, code 20 about 23.3 h.
  wire [HB_W-1:0] hb_last   = last_count(hb_sel); // [RULE5]
  wire [3:0]      wake_last = 4'(last_count({3'h0, wake_interval_sel})); // [RULE3]

  wire hb_expire   = hb_enabled && base_tick && (hb_cnt_reg == hb_last); // [RULE5]
  wire wake_expire = base_tick && (wake_cnt_reg == wake_last); // [RULE3]

  // Set wins over the clear so an expiry coincident with a read is not lost.
  wire hb_flag_next = hb_expire | (hb_flag_reg & ~rd_stat2); // [RULE6] [RULE7]

  // Sign-extend both trims and saturate; the seven-bit range holds every sum, so no factory trim limits the user trim.
  function automatic logic signed [6:0] sat_sum(input logic signed [5:0] a,
                                                input logic signed [5:0] b);
    logic signed [7:0] s;
    s = 8'(signed'(a)) + 8'(signed'(b));
    if (s > 8'sd63)
      sat_sum = 7'sd63;
    else if (s < -8'sd64)
      sat_sum = -7'sd64;
    else
      sat_sum = s[6:0];
  endfunction

  wire signed [5:0] user_trim   = signed'(z_trim_reg[wkt_pkg::TRIM_W-1:0]); // [RULE1]
  wire signed [6:0] gain_next   = sat_sum(user_trim, factory_gain_trim); // [RULE2]

  logic [7:0] rdata_next;
  always_comb begin
    rdata_next = 8'h00;
    case (reg_addr)
      wkt_pkg::ADDR_Z_GAIN_TRIM: rdata_next = z_trim_reg & wkt_pkg::Z_TRIM_MASK;
      wkt_pkg::ADDR_WAKE_AND_HEARTBEAT_TIMER_CONTROL:   rdata_next = wake_and_heartbeat_timer_control_reg;
      wkt_pkg::ADDR_INTMAP1_UP:  rdata_next = intmap1_reg;
      wkt_pkg::ADDR_INTMAP2_UP:  rdata_next = intmap2_reg;
      wkt_pkg::ADDR_SECOND_STATUS_REG:     rdata_next = {3'h0, hb_flag_reg, 4'h0};
      default:                   rdata_next = 8'h00;
    endcase
  end

  // ****************************************
  // Register file
  // ****************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      z_trim_reg    <= wkt_pkg::RST_Z_GAIN_TRIM;
      wake_and_heartbeat_timer_control_reg <= wkt_pkg::RST_WAKE_AND_HEARTBEAT_TIMER_CONTROL; // [RULE3]
      intmap1_reg   <= wkt_pkg::RST_INTMAP;
      intmap2_reg   <= wkt_pkg::RST_INTMAP;
      reg_rdata     <= 8'h00;
    end else begin
      // Trim and map reserved bits are masked on write so readback shows zeros there; the timer control mask keeps all eight bits.
      if (wr_z) begin
        z_trim_reg <= reg_wdata & wkt_pkg::Z_TRIM_MASK; // [RULE1]
      end
      if (wr_tctl) begin
        wake_and_heartbeat_timer_control_reg <= reg_wdata & wkt_pkg::WAKE_AND_HEARTBEAT_TIMER_CONTROL_MASK;
      end
      if (wr_map1) begin
        intmap1_reg <= reg_wdata & wkt_pkg::INTMAP_MASK;
      end
      if (wr_map2) begin
        intmap2_reg <= reg_wdata & wkt_pkg::INTMAP_MASK;
      end
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  // ****************************************
  // Timers and outputs
  // ****************************************
  // Rewriting the control register restarts both periods from zero.
  // The wake timer runs whatever the keep-alive code holds.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wake_cnt_reg <= 4'h0;
    end else if (wr_tctl) begin
      wake_cnt_reg <= 4'h0;
    end else if (base_tick) begin
      wake_cnt_reg <= wake_expire ? 4'h0 : wake_cnt_reg + 4'h1; // [RULE3]
    end
  end

  // Holding the counter at zero while off means a later enable starts a full period.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hb_cnt_reg <= '0;
    end else if (wr_tctl || !hb_enabled) begin
      hb_cnt_reg <= '0; // [RULE4]
    end else if (base_tick) begin
      hb_cnt_reg <= hb_expire ? '0 : hb_cnt_reg + HB_W'(1); // [RULE5]
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      hb_flag_reg <= 1'b0;
    end else begin
      hb_flag_reg <= hb_flag_next; // [RULE6] [RULE7]
    end
  end

  // A control write suppresses the pulses, since the counters restart in that cycle.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wake_pulse      <= 1'b0;
      heartbeat_pulse <= 1'b0;
    end else begin
      wake_pulse      <= wake_expire && !wr_tctl;
      heartbeat_pulse <= hb_expire && !wr_tctl;
    end
  end

  // Pins follow the next flag value so they rise in the same cycle as the flag.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      interrupt_pin_one <= 1'b0;
      interrupt_pin_two <= 1'b0;
    end else begin
      interrupt_pin_one <= hb_flag_next & intmap1_reg[wkt_pkg::HB_MAP_BIT]; // [RULE8] [RULE9]
      interrupt_pin_two <= hb_flag_next & intmap2_reg[wkt_pkg::HB_MAP_BIT]; // [RULE8]
    end
  end

  // The total is registered so the sensing path sees a value free of decode glitches.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      z_gain_total <= 7'sd0;
    end else begin
      z_gain_total <= gain_next; // [RULE2]
    end
  end
endmodule // wakeup_keepalive_timer
`default_nettype wire

// file: rtl/wkt_pkg.sv
// Shared constants for the wake-up and keep-alive timer block.
package wkt_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_SECOND_STATUS_REG     = 8'h0F;
  localparam logic [7:0] ADDR_Z_GAIN_TRIM = 8'h38;
  localparam logic [7:0] ADDR_WAKE_AND_HEARTBEAT_TIMER_CONTROL   = 8'h39;
  localparam logic [7:0] ADDR_INTMAP1_UP  = 8'h3A;
  localparam logic [7:0] ADDR_INTMAP2_UP  = 8'h3B;
  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [7:0] RST_Z_GAIN_TRIM  = 8'h00;
  localparam logic [7:0] RST_WAKE_AND_HEARTBEAT_TIMER_CONTROL    = 8'h00;
  localparam logic [7:0] RST_INTMAP       = 8'h00;
  localparam int         TRIM_W           = 6;
  localparam int         TRIM_SIGN_BIT    = 5;
  localparam int         WAKE_SEL_LSB     = 6;
  localparam int         HB_SEL_W         = 5;
  localparam int         HB_STATUS_BIT    = 4;
  localparam int         HB_MAP_BIT       = 4;
  localparam logic [7:0] WAKE_AND_HEARTBEAT_TIMER_CONTROL_MASK   = 8'hFF;
  localparam logic [7:0] Z_TRIM_MASK      = 8'h3F;
  localparam logic [7:0] INTMAP_MASK      = 8'hDF;
  // ****************************************
  // Timing
  // ****************************************
  localparam int         CLK_MHZ          = 200;
  localparam int         BASE_TICK_MS     = 80;
  localparam int         BASE_TICK_CYCLES = BASE_TICK_MS * CLK_MHZ * 1000;
  localparam logic [4:0] HB_CODE_OFF      = 5'h00;
  localparam logic [4:0] HB_CODE_MAX      = 5'h14;
  localparam int         HB_CNT_W         = 21;
  // ****************************************
  // Combined gain trim range
  // ****************************************
  localparam int         GAIN_SUM_W       = 7;
endpackage : wkt_pkg

// file: rtl/tick_divider.sv
// Divider that produces a one-cycle enable pulse every DIV clock cycles.
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int DIV = wkt_pkg::BASE_TICK_CYCLES
) (
  input  wire logic clk,
  input  wire logic resetn,
  output logic      tick
);
  logic [31:0] cnt_reg;
  wire         at_end = (cnt_reg == 32'(DIV - 1));

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_reg <= 32'h0000_0000;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= at_end ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
      tick    <= at_end;
    end
  end
endmodule // tick_divider
`default_nettype wire

// file: bench/wkt_chk.sv
// Port checker for the wake-up and keep-alive timer.
`timescale 1ns/1ps
`default_nettype none
module wkt_chk (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       wake_pulse,
  input wire logic       heartbeat_pulse,
  input wire logic       interrupt_pin_one,
  input wire logic       interrupt_pin_two
);
  logic [7:0] ctl_reg;
  logic       map1_reg;
  wire        hb_idle = ctl_reg[4:0] == 5'h00 || ctl_reg[4:0] > 5'h14;
  always_ff @(posedge clk) begin
    if (!resetn) ctl_reg <= 8'h00;
    else if (reg_wr && reg_addr == wkt_pkg::ADDR_WAKE_AND_HEARTBEAT_TIMER_CONTROL) ctl_reg <= reg_wdata;
  end
  always_ff @(posedge clk) begin
    if (!resetn) map1_reg <= 1'b0;
    else if (reg_wr && reg_addr == wkt_pkg::ADDR_INTMAP1_UP) map1_reg <= reg_wdata[4];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // A read that no expiry overtakes within two cycles.
  sequence status_read;
    (reg_rd && reg_addr == wkt_pkg::ADDR_SECOND_STATUS_REG) ##1 !heartbeat_pulse [*2];
  endsequence
  trim_read_a: assert property (reg_rd && reg_addr == wkt_pkg::ADDR_Z_GAIN_TRIM
    |=> reg_rdata[7:6] == 2'b00) else $error("trim top bits set");
  ctl_read_a: assert property (reg_rd && !reg_wr && reg_addr == wkt_pkg::ADDR_WAKE_AND_HEARTBEAT_TIMER_CONTROL
    |=> reg_rdata == ctl_reg) else $error("timer control readback wrong");
  hb_off_a: assert property (hb_idle && !$past(reg_wr) |-> !heartbeat_pulse)
    else $error("keep-alive fired while off");
  pin1_mask_a: assert property (!map1_reg && !$past(reg_wr) |-> !interrupt_pin_one)
    else $error("pin one without map");
  pin1_raise_a: assert property (heartbeat_pulse && map1_reg && !reg_rd
    |-> ##[0:1] interrupt_pin_one) else $error("pin one missed expiry");
  status_clr_a: assert property (status_read |-> !interrupt_pin_one && !interrupt_pin_two)
    else $error("status read left pin high");
  wake_gap_a: assert property (wake_pulse |=> !wake_pulse [*8])
    else $error("wake pulses too close");
  hb_len_a: assert property (heartbeat_pulse |=> !heartbeat_pulse)
    else $error("keep-alive pulse too long");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
endmodule // wkt_chk
bind wakeup_keepalive_timer wkt_chk i_chk (.clk, .resetn, .reg_addr, .reg_wr, .reg_wdata,
  .reg_rd, .reg_rdata, .wake_pulse, .heartbeat_pulse, .interrupt_pin_one, .interrupt_pin_two);
`default_nettype wire

// file: bench/host_model.sv
// Host model that issues single-byte register accesses.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk,
  output logic      [7:0] reg_addr = 8'h00,
  output logic            reg_wr = 1'b0,
  output logic      [7:0] reg_wdata = 8'h00,
  output logic            reg_rd = 1'b0
);
  // Released address and data lines show the inverse, and the strobes drop to zero, so stale values are never mistaken for live ones.
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule // host_model
`default_nettype wire

// file: bench/testbench.sv
// Self-checking testbench for the wake-up and keep-alive timer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int BASE = 10;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic signed [5:0] factory_gain_trim = 6'sh00;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, wake_pulse, heartbeat_pulse, interrupt_pin_one, interrupt_pin_two;
  wire signed [6:0] z_gain_total;
  logic [7:0] exp_q[$];
  logic [7:0] u;
  logic rd_pend = 1'b0;
  int miscompares = 0, cmp_count = 0, seed = 32'h96b01c55, n;
  host_model i_host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
  wakeup_keepalive_timer #(.BASE_TICK_CYCLES(BASE)) i_dut (.clk, .resetn, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .factory_gain_trim, .z_gain_total, .wake_pulse,
    .heartbeat_pulse, .interrupt_pin_one, .interrupt_pin_two);
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.access(1'b0, a, 8'h00);
  endtask
  task automatic gap(input logic hb, output int c);
    c = 0;
    do begin @(negedge clk); c++; end while ((hb ? heartbeat_pulse : wake_pulse) !== 1'b1 && c < 999);
    c = 0;
    do begin @(negedge clk); c++; end while ((hb ? heartbeat_pulse : wake_pulse) !== 1'b1 && c < 999);
  endtask
  always @(posedge clk) begin
    if (rd_pend) chk(reg_rdata, exp_q.pop_front());
    rd_pend <= reg_rd;
  end
  initial begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    rd(wkt_pkg::ADDR_Z_GAIN_TRIM, 8'h00);
    rd(wkt_pkg::ADDR_WAKE_AND_HEARTBEAT_TIMER_CONTROL, 8'h00);
    rd(8'h00, 8'h00);
    $display("reset values done");
    repeat (4) begin
      u = 8'($random(seed));
      factory_gain_trim = 6'($random(seed));
      i_host.access(1'b1, wkt_pkg::ADDR_Z_GAIN_TRIM, u);
      rd(wkt_pkg::ADDR_Z_GAIN_TRIM, {2'b00, u[5:0]});
      chk(8'(z_gain_total), 8'($signed(u[5:0]) + factory_gain_trim));
    end
    $display("trim done");
    for (int s = 0; s < 4; s++) begin
      i_host.access(1'b1, wkt_pkg::ADDR_WAKE_AND_HEARTBEAT_TIMER_CONTROL, 8'(s << 6));
      gap(1'b0, n);
      chk(8'(n), 8'(BASE << s));
    end
    $display("wake intervals done");
    for (int m = 0; m < 2; m++) begin
      i_host.access(1'b1, wkt_pkg::ADDR_INTMAP1_UP, m ? 8'h00 : 8'h10);
      i_host.access(1'b1, wkt_pkg::ADDR_INTMAP2_UP, m ? 8'h10 : 8'h00);
      i_host.access(1'b1, wkt_pkg::ADDR_WAKE_AND_HEARTBEAT_TIMER_CONTROL, 8'(m + 1));
      gap(1'b1, n);
      chk(8'(n), 8'(BASE << (m + 1)));
      @(negedge clk);
      chk({6'h00, interrupt_pin_two, interrupt_pin_one}, m ? 8'h02 : 8'h01);
      rd(wkt_pkg::ADDR_SECOND_STATUS_REG, 8'h10);
      @(negedge clk);
      chk({6'h00, interrupt_pin_two, interrupt_pin_one}, 8'h00);
      $display("keep-alive route %0d done", m);
    end
    for (int k = 0; k < 2; k++) begin
      i_host.access(1'b1, wkt_pkg::ADDR_WAKE_AND_HEARTBEAT_TIMER_CONTROL, k ? 8'h15 : 8'h00);
      repeat (BASE * 8) @(negedge clk);
      rd(wkt_pkg::ADDR_SECOND_STATUS_REG, 8'h00);
    end
    $display("idle codes done");
    repeat (3) @(negedge clk);
    tally_and_finish();
  end
  initial begin
    #20000;
    miscompares++;
    tally_and_finish();
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
endmodule // testbench
`default_nettype wire
